// ==== anr_ability_regs.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - advertisement bit 15 is a read-only next-page flag held at a fixed value of 0.
// - advertisement bit 13 is written by management to signal a local fault to the partner.
// - advertisement bits 11:10 code the pause ability, bit 11 writable and reset to 0.
// - advertisement bit 10 is writable and takes the pause strap level when reset is released.
// - advertisement bit 9 always reads 0 so four-pair operation is never offered.
// - advertisement bits 8:5 are writable capability flags that reset to 1.
// - the final speed and duplex combine bits 8:6 with the speed and duplex straps.
// - advertisement bits 4:0 always read the selector code 00001b.
// - partner bit 15 reports partner next-page ability and resets to 0.
// - partner bit 14 reports the partner acknowledge and resets to 0.
// - partner bit 13 reports the partner remote fault and resets to 0.
// - partner bit 11 reports the partner asymmetric pause direction and resets to 0.
// - partner bit 10 reports partner pause ability, resets to 0 and takes the pause strap when reset is released.
// - partner bits 9 to 5 report the partner technology abilities and reset to 0.
// - the remote fault status latches on partner bit 13 and clears on a status read once stored partner bit 13 is 0.
module anr_ability_regs
  import anr_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic MDC,
  input wire logic MDIO_I,
  output logic MDIO_O,
  output logic MDIO_OE,
  input wire logic [4:0] PHY_ADDR,
  input wire logic FLOW_CTL_STRAP,
  input wire logic SPEED_STRAP,
  input wire logic DUPLEX_STRAP,
  input wire logic PAGE_RX_VALID,
  input wire logic [15:0] PAGE_RX_WORD,
  input wire logic STATUS_READ,
  output logic [15:0] ADV_WORD,
  output logic REMOTE_FAULT_STATUS,
  output logic SPEED_100,
  output logic FULL_DUPLEX
);

  logic mdc_s;
  logic mdio_s;
  logic flow_ctl_strap_s;
  logic speed_strap_s;
  logic duplex_strap_s;
  logic mdc_d1_q;
  logic mdc_rise;

  anr_sync #(.WIDTH(5)) u_sync (
    .clk(CLK),
    .d({MDC, MDIO_I, FLOW_CTL_STRAP, SPEED_STRAP, DUPLEX_STRAP}),
    .q({mdc_s, mdio_s, flow_ctl_strap_s, speed_strap_s, duplex_strap_s})
  );

  always_ff @(posedge CLK) begin
    if (SRST) begin
      // reset high so a clock left high through reset gives no false rise
      mdc_d1_q <= 1'b1;
    end else begin
      mdc_d1_q <= mdc_s;
    end
  end

  assign mdc_rise = mdc_s & ~mdc_d1_q;

  // ---------------- management frame engine ----------------
  anr_mstate_t state_q;
  logic [5:0] pre_cnt_q;
  logic pre_ok_q;
  logic [13:0] hdr_q;
  logic [13:0] hdr_next;
  logic [4:0] cnt_q;
  logic [15:0] sh_q;
  logic rd_q;
  logic hit_q;
  logic [4:0] reg_addr_q;
  logic wr_stb_q;
  logic [15:0] wr_data_q;
  logic [15:0] rd_data;

  assign hdr_next = {hdr_q[12:0], mdio_s};

  // preamble suppression is allowed only after one full preamble since reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      pre_cnt_q <= 6'h00;
      pre_ok_q <= 1'b0;
    end else if (mdc_rise && state_q == ANR_MS_IDLE) begin
      if (mdio_s) begin
        if (pre_cnt_q != ANR_PREAMBLE_MIN) begin
          pre_cnt_q <= pre_cnt_q + 6'h01;
        end
        if (pre_cnt_q == ANR_PREAMBLE_MIN - 6'h01) begin
          pre_ok_q <= 1'b1;
        end
      end else begin
        pre_cnt_q <= 6'h00;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= ANR_MS_IDLE;
      hdr_q <= 14'h0000;
      cnt_q <= 5'h00;
      sh_q <= 16'h0000;
      rd_q <= 1'b0;
      hit_q <= 1'b0;
      reg_addr_q <= 5'h00;
      wr_stb_q <= 1'b0;
      wr_data_q <= 16'h0000;
      MDIO_O <= 1'b0;
      MDIO_OE <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      if (mdc_rise) begin
        case (state_q)
          ANR_MS_IDLE: begin
            // a zero after the idle ones is the first start bit
            if (!mdio_s && pre_ok_q) begin
              hdr_q <= 14'h0000;
              cnt_q <= ANR_HDR_REST;
              state_q <= ANR_MS_HDR;
            end
          end
          ANR_MS_HDR: begin
            hdr_q <= hdr_next;
            if (cnt_q == 5'h00) begin
              rd_q <= (hdr_next[11:10] == ANR_MF_OP_RD);
              hit_q <= (hdr_next[13:12] == ANR_MF_START) &&
                       ((hdr_next[11:10] == ANR_MF_OP_RD) ||
                        (hdr_next[11:10] == ANR_MF_OP_WR)) &&
                       (hdr_next[9:5] == PHY_ADDR) &&
                       anr_mapped(hdr_next[4:0]);
              reg_addr_q <= hdr_next[4:0];
              state_q <= ANR_MS_TA1;
            end else begin
              cnt_q <= cnt_q - 5'h01;
            end
          end
          ANR_MS_TA1: begin
            // first turnaround bit stays released, second is driven low
            state_q <= ANR_MS_TA2;
            if (rd_q && hit_q) begin
              MDIO_OE <= 1'b1;
              MDIO_O <= 1'b0;
            end
          end
          ANR_MS_TA2: begin
            state_q <= ANR_MS_DATA;
            cnt_q <= ANR_DATA_LAST;
            if (rd_q && hit_q) begin
              MDIO_O <= rd_data[15];
              sh_q <= {rd_data[14:0], 1'b0};
            end else begin
              sh_q <= 16'h0000;
            end
          end
          ANR_MS_DATA: begin
            if (rd_q) begin
              MDIO_O <= sh_q[15];
              sh_q <= {sh_q[14:0], 1'b0};
            end else begin
              sh_q <= {sh_q[14:0], mdio_s};
            end
            if (cnt_q == 5'h00) begin
              state_q <= ANR_MS_IDLE;
              MDIO_OE <= 1'b0;
              MDIO_O <= 1'b0;
              if (!rd_q && hit_q) begin
                wr_stb_q <= 1'b1;
                wr_data_q <= {sh_q[14:0], mdio_s};
              end
            end else begin
              cnt_q <= cnt_q - 5'h01;
            end
          end
          default: begin
            state_q <= ANR_MS_IDLE;
            MDIO_OE <= 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------- local advertisement ----------------
  logic rf_q;
  logic asym_q;
  logic pause_q;
  logic [3:0] cap_q;
  logic strap_pend_q;
  logic adv_wr;

  assign adv_wr = wr_stb_q && (reg_addr_q == ANR_REG_ADV);

  // one cycle after reset release the synchronised flow control strap is sampled
  always_ff @(posedge CLK) begin
    if (SRST) begin
      strap_pend_q <= 1'b1;
    end else begin
      strap_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      rf_q <= ANR_RF_RST;
    end else if (adv_wr) begin
      rf_q <= wr_data_q[ANR_ADV_RF];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      asym_q <= ANR_ASYM_RST;
    end else if (adv_wr) begin
      asym_q <= wr_data_q[ANR_ADV_ASYM];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      pause_q <= ANR_PAUSE_RST;
    end else if (strap_pend_q) begin
      pause_q <= flow_ctl_strap_s;
    end else if (adv_wr) begin
      pause_q <= wr_data_q[ANR_ADV_PAUSE];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      cap_q <= ANR_CAP_RST;
    end else if (adv_wr) begin
      cap_q <= wr_data_q[ANR_ADV_CAP_HI:ANR_ADV_CAP_LO];
    end
  end

  // read-only and reserved bits come from constants, never from writes
  assign ADV_WORD = {ANR_NP_VAL,
                     1'b0,
                     rf_q,
                     1'b0,
                     asym_q,
                     pause_q,
                     ANR_T4_VAL,
                     cap_q,
                     ANR_SELECTOR};

  // ---------------- link partner ability ----------------
  logic [15:0] lpa_q;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      lpa_q <= ANR_LPA_RST;
    end else if (PAGE_RX_VALID) begin
      lpa_q <= PAGE_RX_WORD & ANR_LPA_MASK;
    end else if (strap_pend_q) begin
      lpa_q[ANR_LPA_PAUSE] <= flow_ctl_strap_s;
    end
  end

  // register reads; the partner word ignores management writes
  always_comb begin
    rd_data = 16'h0000;
    case (reg_addr_q)
      ANR_REG_ADV: rd_data = ADV_WORD;
      ANR_REG_LPA: rd_data = lpa_q;
      default: rd_data = 16'h0000;
    endcase
  end

  // ---------------- fault latch and resolved mode ----------------
  // a new fault in the clearing cycle keeps the flag set
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REMOTE_FAULT_STATUS <= 1'b0;
    end else begin
      REMOTE_FAULT_STATUS <= lpa_q[ANR_LPA_RF] | (REMOTE_FAULT_STATUS & ~STATUS_READ);
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SPEED_100 <= 1'b0;
      FULL_DUPLEX <= 1'b0;
    end else begin
      SPEED_100 <= speed_strap_s &
                   (cap_q[ANR_CAP_FAST_FULL] | cap_q[ANR_CAP_FAST_HALF]);
      FULL_DUPLEX <= duplex_strap_s &
                     ((speed_strap_s &
                       (cap_q[ANR_CAP_FAST_FULL] | cap_q[ANR_CAP_FAST_HALF])) ?
                      cap_q[ANR_CAP_FAST_FULL] : cap_q[ANR_CAP_SLOW_FULL]);
    end
  end

endmodule // anr_ability_regs

// ==== anr_pkg.sv ====
package anr_pkg;

  // management register addresses
  localparam logic [4:0] ANR_REG_ADV = 5'h04;
  localparam logic [4:0] ANR_REG_LPA = 5'h05;

  // advertisement word field positions
  localparam int ANR_ADV_NP = 15;
  localparam int ANR_ADV_RSV14 = 14;
  localparam int ANR_ADV_RF = 13;
  localparam int ANR_ADV_RSV12 = 12;
  localparam int ANR_ADV_ASYM = 11;
  localparam int ANR_ADV_PAUSE = 10;
  localparam int ANR_ADV_T4 = 9;
  localparam int ANR_ADV_CAP_HI = 8;
  localparam int ANR_ADV_CAP_LO = 5;

  // partner word field positions
  localparam int ANR_LPA_NP = 15;
  localparam int ANR_LPA_ACK = 14;
  localparam int ANR_LPA_RF = 13;
  localparam int ANR_LPA_ASYM = 11;
  localparam int ANR_LPA_PAUSE = 10;

  // capability nibble positions within bits 8:5
  localparam int ANR_CAP_FAST_FULL = 3;
  localparam int ANR_CAP_FAST_HALF = 2;
  localparam int ANR_CAP_SLOW_FULL = 1;
  localparam int ANR_CAP_SLOW_HALF = 0;

  // reset and fixed values
  localparam logic ANR_NP_VAL = 1'b0;
  localparam logic ANR_T4_VAL = 1'b0;
  localparam logic ANR_RF_RST = 1'b0;
  localparam logic ANR_ASYM_RST = 1'b0;
  localparam logic ANR_PAUSE_RST = 1'b1;
  localparam logic [3:0] ANR_CAP_RST = 4'hF;
  localparam logic [4:0] ANR_SELECTOR = 5'h01;
  localparam logic [15:0] ANR_LPA_RST = 16'h0001;
  // bit 12 of the received page is reserved and never stored
  localparam logic [15:0] ANR_LPA_MASK = 16'hEFFF;

  // management frame layout
  localparam logic [1:0] ANR_MF_START = 2'b01;
  localparam logic [1:0] ANR_MF_OP_RD = 2'b10;
  localparam logic [1:0] ANR_MF_OP_WR = 2'b01;
  localparam logic [5:0] ANR_PREAMBLE_MIN = 6'h20;
  localparam logic [4:0] ANR_HDR_REST = 5'h0C;
  localparam logic [4:0] ANR_DATA_LAST = 5'h0F;

  typedef enum logic [2:0] {
    ANR_MS_IDLE,
    ANR_MS_HDR,
    ANR_MS_TA1,
    ANR_MS_TA2,
    ANR_MS_DATA
  } anr_mstate_t;

  function automatic logic anr_mapped(input logic [4:0] addr);
    anr_mapped = (addr == ANR_REG_ADV) || (addr == ANR_REG_LPA);
  endfunction

endpackage

// ==== anr_sync.sv ====
`timescale 1ns/1ps
module anr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end

endmodule // anr_sync

// ==== anr_ability_regs_chk.sv ====
`timescale 1ns/1ps
module anr_ability_regs_chk (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic FLOW_CTL_STRAP,
  input wire logic SPEED_STRAP,
  input wire logic DUPLEX_STRAP,
  input wire logic PAGE_RX_VALID,
  input wire logic [15:0] PAGE_RX_WORD,
  input wire logic STATUS_READ,
  input wire logic [15:0] ADV_WORD,
  input wire logic REMOTE_FAULT_STATUS,
  input wire logic SPEED_100,
  input wire logic FULL_DUPLEX
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  a_selector_fixed: assert property (ADV_WORD[4:0] == 5'h01)
    else $error("selector field wrong");
  a_fixed_zero: assert property ({ADV_WORD[15:14], ADV_WORD[12], ADV_WORD[9]} == 4'h0)
    else $error("fixed advertisement bit set");
  a_fault_set: assert property (PAGE_RX_VALID && PAGE_RX_WORD[13] |=> ##1
    REMOTE_FAULT_STATUS) else $error("remote fault not latched");
  a_fault_hold: assert property (REMOTE_FAULT_STATUS && !STATUS_READ |=>
    REMOTE_FAULT_STATUS) else $error("remote fault dropped without status read");
  a_fault_clear: assert property ($fell(REMOTE_FAULT_STATUS) |-> $past(STATUS_READ))
    else $error("remote fault cleared without cause");
  a_speed_off: assert property ((!SPEED_STRAP)[*4] |-> !SPEED_100)
    else $error("100M resolved with strap low");
  a_duplex_off: assert property ((!DUPLEX_STRAP)[*4] |-> !FULL_DUPLEX)
    else $error("full duplex resolved with strap low");
  a_fast_half: assert property ((SPEED_STRAP && ADV_WORD[8:7] == 2'b01)[*4] |->
    SPEED_100 && !FULL_DUPLEX) else $error("fast half resolution wrong");
  a_no_caps: assert property ((ADV_WORD[8:5] == 4'h0)[*4] |-> !SPEED_100 && !FULL_DUPLEX)
    else $error("mode resolved without abilities");
  a_reset_word: assert property ($fell(SRST) |-> ADV_WORD == 16'h05E1 &&
    !REMOTE_FAULT_STATUS) else $error("reset values wrong");
  a_pause_strap: assert property ($fell(SRST) |=> ADV_WORD[10] == FLOW_CTL_STRAP)
    else $error("pause bit did not take strap");
endmodule // anr_ability_regs_chk

bind anr_ability_regs anr_ability_regs_chk anr_ability_regs_chk_i (.CLK, .SRST, .FLOW_CTL_STRAP,
  .SPEED_STRAP, .DUPLEX_STRAP, .PAGE_RX_VALID, .PAGE_RX_WORD, .STATUS_READ, .ADV_WORD,
  .REMOTE_FAULT_STATUS, .SPEED_100, .FULL_DUPLEX);

// ==== anr_station.sv ====
`timescale 1ns/1ps
module anr_station (
  input wire logic clk,
  input wire logic mdio,
  output logic mdc,
  output logic drv
);
  initial begin
    mdc = 1'b0;
    drv = 1'b1;
  end
  // drv sets the wire level directly whenever oe is low; there is no pull-up
  task automatic mbit(input logic b, output logic s);
    @(posedge clk);
    mdc <= 1'b0;
    drv <= b;
    repeat (4) @(posedge clk);
    @(negedge clk);
    s = mdio;
    @(posedge clk);
    mdc <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic pre();
    logic s;
    repeat (32) mbit(1'b1, s);
  endtask
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] f;
    logic s;
    logic wr;
    wr = (op == 2'b01);
    f = {2'b01, op, pa, ra, wr ? 2'b10 : 2'b11, wr ? wd : 16'hFFFF};
    for (int i = 31; i >= 0; i--) begin
      mbit(f[i], s);
      rd = {rd[14:0], s};
    end
    mbit(1'b1, s);
  endtask
endmodule // anr_station

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import anr_pkg::*;
  localparam logic [4:0] PA = 5'h03;
  logic clk, srst, fstrap, sstrap, dstrap, pv, sr, mo, oe, mdc, drv, sp, fd, rfs;
  logic [15:0] pw, adv, rd;
  wire mdio;
  int errors, checks;
  assign mdio = oe ? mo : drv;
  anr_ability_regs anr_ability_regs_i (.CLK(clk), .SRST(srst), .MDC(mdc), .MDIO_I(mdio),
    .MDIO_O(mo), .MDIO_OE(oe), .PHY_ADDR(PA), .FLOW_CTL_STRAP(fstrap), .SPEED_STRAP(sstrap),
    .DUPLEX_STRAP(dstrap), .PAGE_RX_VALID(pv), .PAGE_RX_WORD(pw), .STATUS_READ(sr),
    .ADV_WORD(adv), .REMOTE_FAULT_STATUS(rfs), .SPEED_100(sp), .FULL_DUPLEX(fd));
  anr_station anr_station_i (.clk(clk), .mdio(mdio), .mdc(mdc), .drv(drv));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    anr_station_i.xfer(2'b01, PA, ra, d, rd);
  endtask
  task automatic rc(input string n, input logic [4:0] pa, input logic [4:0] ra,
                    input logic [15:0] exp);
    anr_station_i.xfer(2'b10, pa, ra, 16'h0000, rd);
    chk(n, rd, exp);
  endtask
  task automatic page(input logic [15:0] w);
    @(posedge clk);
    pv <= 1'b1;
    pw <= w;
    @(posedge clk);
    pv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic do_reset(input logic f);
    @(posedge clk);
    fstrap <= f;
    srst <= 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    anr_station_i.pre();
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    close_out();
  end
  initial begin
    srst = 1'b1;
    fstrap = 1'b0;
    sstrap = 1'b1;
    dstrap = 1'b1;
    pv = 1'b0;
    pw = 16'h0000;
    sr = 1'b0;
    do_reset(1'b0);
    rc("adv reset", PA, ANR_REG_ADV, 16'h01E1);
    rc("partner reset", PA, ANR_REG_LPA, 16'h0001);
    chk("speed duplex", {14'h0000, sp, fd}, 16'h0003);
    $display("test reset done");
    wr(ANR_REG_ADV, 16'hFFFF);
    rc("adv all ones", PA, ANR_REG_ADV, 16'h2DE1);
    chk("adv port", adv, 16'h2DE1);
    for (int c = 0; c < 4; c++) begin
      wr(ANR_REG_ADV, 16'(c << 10));
      rc("pause code", PA, ANR_REG_ADV, 16'(c << 10) | 16'h0001);
    end
    chk("no caps", {14'h0000, sp, fd}, 16'h0000);
    wr(ANR_REG_ADV, 16'h0080);
    chk("fast half", {14'h0000, sp, fd}, 16'h0002);
    wr(ANR_REG_ADV, 16'h0140);
    chk("fast full", {14'h0000, sp, fd}, 16'h0003);
    @(posedge clk);
    sstrap <= 1'b0;
    repeat (6) @(posedge clk);
    chk("slow full", {14'h0000, sp, fd}, 16'h0001);
    dstrap <= 1'b0;
    repeat (6) @(posedge clk);
    chk("duplex off", {14'h0000, sp, fd}, 16'h0000);
    $display("test writes done");
    wr(ANR_REG_LPA, 16'hFFFF);
    rc("partner after write", PA, ANR_REG_LPA, 16'h0001);
    rc("other phy", PA ^ 5'h01, ANR_REG_ADV, 16'hFFFF);
    rc("unmapped", PA, 5'h06, 16'hFFFF);
    anr_station_i.xfer(2'b11, PA, ANR_REG_ADV, 16'h0000, rd);
    chk("bad op", rd, 16'hFFFF);
    $display("test refusals done");
    page(16'hFFFF);
    rc("partner page", PA, ANR_REG_LPA, 16'hEFFF);
    chk("fault latched", {15'h0000, rfs}, 16'h0001);
    page(16'h0000);
    chk("fault held", {15'h0000, rfs}, 16'h0001);
    @(posedge clk);
    sr <= 1'b1;
    @(posedge clk);
    sr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("fault cleared", {15'h0000, rfs}, 16'h0000);
    $display("test partner done");
    do_reset(1'b1);
    rc("adv strap high", PA, ANR_REG_ADV, 16'h05E1);
    rc("partner strap high", PA, ANR_REG_LPA, 16'h0401);
    $display("test strap done");
    close_out();
  end
endmodule // tb_top
